// ---- bench/pmt_timer_assertions.sv ----
// Port checks of the period match timer.
`timescale 1ns/1ps
module pmt_timer_assertions (
  input wire logic              clk,
  input wire logic              rst,
  input wire logic              hsel,
  input wire logic [1:0]        htrans,
  input wire logic              hwrite,
  input wire logic              hready,
  input wire logic              hreadyout,
  input wire logic [31:0]       hrdata,
  input wire logic              serialShiftMatch,
  input wire pmt_pkg::pmt_pwm_t pwmTimebase
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence taken(logic w);
    hsel && hready && htrans == 2'h2 && hwrite == w;
  endsequence
  sequence waitOne;
    !hreadyout ##1 hreadyout;
  endsequence
  a_read_wait: assert property (taken(1'b0) |=> waitOne)
    else $error("read wait state wrong");
  a_write_fast: assert property (taken(1'b1) |=> hreadyout)
    else $error("write stalled");
  a_read_byte: assert property (hrdata[31:8] == 24'h000000)
    else $error("read data upper bits set");
  a_match_zero: assert property (serialShiftMatch |=> pwmTimebase.count == 8'h00)
    else $error("count not zero after match");
  a_match_top: assert property (serialShiftMatch |-> pwmTimebase.count == pwmTimebase.period)
    else $error("match without count at period");
  a_match_space: assert property (serialShiftMatch |=> !serialShiftMatch [*3])
    else $error("matches closer than four cycles");
  a_pwm_match: assert property (pwmTimebase.match == serialShiftMatch)
    else $error("time-base match differs");
  a_reset_zero: assert property ($past(rst) |-> pwmTimebase.count == 8'h00)
    else $error("count not zero after reset");
endmodule

// ---- bench/tb_top.sv ----
// Self-checking bench of the period match timer.
`timescale 1ns/1ps
module tb_top;
  logic        clk, rst, hsel, hwrite, hreadyout, hresp, irq, serialShiftMatch;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [7:0]  rnd;
  int          numErrors, checked, n, p;

  pmt_period_match_timer8 u_dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq),
    .serialShiftMatch(serialShiftMatch), .pwmTimebase());

  always #20 clk = ~clk;

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      numErrors++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask

  // The ready level is taken at the falling edge; it cannot move before the next rise.
  task automatic waitRdy;
    logic ok;
    do begin
      @(negedge clk);
      ok = hreadyout;
      @(posedge clk);
    end while (ok !== 1'b1);
  endtask

  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
    hsel <= 1'b1;
    haddr <= {20'h00000, a};
    htrans <= pmt_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    hsize <= pmt_pkg::HSIZE_WORD;
    waitRdy();
    htrans <= 2'h0;
    hwdata <= {24'h000000, d};
    waitRdy();
    rd = hrdata;
  endtask

  task automatic rdChk(input string nm, input logic [11:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    chk(nm, {24'h000000, e}, rd);
    chk("hresp", 32'h00000000, {31'h00000000, hresp});
  endtask

  task automatic gap(output int c);
    c = 0;
    do begin
      @(negedge clk);
      c++;
    end while (serialShiftMatch !== 1'b1);
  endtask

  task automatic final_report;
    $display("checks %0d errors %0d", checked, numErrors);
    if (numErrors == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    #2000000;
    numErrors++;
    final_report();
  end

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    rnd = 8'h1C;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdChk("period", pmt_pkg::ADDR_PER, 8'hFF);
    rdChk("count", pmt_pkg::ADDR_COUNT, 8'h00);
    rdChk("control", pmt_pkg::ADDR_CTRL, 8'h00);
    rdChk("flags", pmt_pkg::ADDR_FLAGS, 8'h00);
    rdChk("enables", pmt_pkg::ADDR_ENAB, 8'h00);
    rdChk("unmapped", 12'h004, 8'h00);
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      xfer(1'b1, pmt_pkg::ADDR_COUNT, rnd);
      xfer(1'b1, pmt_pkg::ADDR_CTRL, (rnd | 8'h80) & 8'hFB);
      xfer(1'b1, pmt_pkg::ADDR_ENAB, ~rnd);
      xfer(1'b1, pmt_pkg::ADDR_PER, rnd ^ 8'hC3);
      repeat (40) @(posedge clk);
      rdChk("control", pmt_pkg::ADDR_CTRL, rnd & 8'h7B);
      rdChk("count", pmt_pkg::ADDR_COUNT, rnd);
      rdChk("enables", pmt_pkg::ADDR_ENAB, ~rnd);
      rdChk("period", pmt_pkg::ADDR_PER, rnd ^ 8'hC3);
    end
    xfer(1'b1, pmt_pkg::ADDR_PER, 8'h03);
    for (int s = 0; s < 4; s++) begin
      xfer(1'b1, pmt_pkg::ADDR_COUNT, 8'h00);
      xfer(1'b1, pmt_pkg::ADDR_CTRL, 8'h04 | 8'(s));
      gap(n);
      gap(n);
      chk("interval", 16 * (s == 0 ? 1 : (s == 1 ? 4 : 16)), n);
      @(posedge clk);
    end
    xfer(1'b1, pmt_pkg::ADDR_ENAB, 8'h02);
    for (int k = 0; k < 3; k++) begin
      p = (k == 2) ? 15 : k * 3;
      xfer(1'b1, pmt_pkg::ADDR_CTRL, 8'h00);
      xfer(1'b1, pmt_pkg::ADDR_COUNT, 8'h00);
      xfer(1'b0, pmt_pkg::ADDR_FLAGS, 8'h00);
      xfer(1'b1, pmt_pkg::ADDR_CTRL, {1'b0, 4'(p), 3'h4});
      n = 0;
      while (irq !== 1'b1) begin
        @(negedge clk);
        if (serialShiftMatch === 1'b1) n++;
      end
      @(posedge clk);
      chk("matches", p + 1, n);
    end
    xfer(1'b1, pmt_pkg::ADDR_CTRL, 8'h00);
    xfer(1'b1, pmt_pkg::ADDR_ENAB, 8'h00);
    repeat (2) @(posedge clk);
    chk("irq", 32'h00000000, {31'h00000000, irq});
    rdChk("flags", pmt_pkg::ADDR_FLAGS, 8'h02);
    rdChk("flags", pmt_pkg::ADDR_FLAGS, 8'h00);
    final_report();
  end
endmodule

bind pmt_period_match_timer8 pmt_timer_assertions u_chk (.clk(clk), .rst(rst), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
  .serialShiftMatch(serialShiftMatch), .pwmTimebase(pwmTimebase));

// ---- rtl/pmt_period_match_timer8.sv ----
// Eight-bit period match timer with prescaler, postscaler and AHB-Lite registers.
`timescale 1ns/1ps

module pmt_period_match_timer8 (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  output logic                   irq,
  output logic                   serialShiftMatch,
  output pmt_pkg::pmt_pwm_t      pwmTimebase
);

  // ****************************************************************
  // Bus slave
  // ****************************************************************
  logic                        wrPend;
  logic                        rdWait;
  logic [pmt_pkg::ADDR_W-1:0]  dataAddr;
  logic                        addrPhase;
  logic                        goodAccess;

  function automatic logic hitReg(input logic [pmt_pkg::ADDR_W-1:0] a,
                                  input logic [pmt_pkg::ADDR_W-1:0] target);
    hitReg = (a == target);
  endfunction

  assign addrPhase  = hsel & hready & (htrans == pmt_pkg::HTRANS_NONSEQ);
  assign goodAccess = (hsize == pmt_pkg::HSIZE_WORD) && (haddr[31:pmt_pkg::ADDR_W] == '0);
  assign hreadyout  = ~rdWait;
  assign hresp      = 1'b0;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wrPend   <= 1'b0;
      rdWait   <= 1'b0;
      dataAddr <= '0;
    end else begin
      rdWait <= 1'b0;
      wrPend <= 1'b0;
      if (addrPhase) begin
        dataAddr <= haddr[pmt_pkg::ADDR_W-1:0];
        wrPend   <= hwrite & goodAccess;
        rdWait   <= ~hwrite;
      end
    end
  end

  logic wrFlags;
  logic wrCount;
  logic wrCtrl;
  logic wrEnab;
  logic wrPer;
  logic rdFlags;

  assign wrFlags = wrPend & hitReg(dataAddr, pmt_pkg::ADDR_FLAGS);
  assign wrCount = wrPend & hitReg(dataAddr, pmt_pkg::ADDR_COUNT);
  assign wrCtrl  = wrPend & hitReg(dataAddr, pmt_pkg::ADDR_CTRL);
  assign wrEnab  = wrPend & hitReg(dataAddr, pmt_pkg::ADDR_ENAB);
  assign wrPer   = wrPend & hitReg(dataAddr, pmt_pkg::ADDR_PER);
  assign rdFlags = rdWait & hitReg(dataAddr, pmt_pkg::ADDR_FLAGS);

  // ****************************************************************
  // Registers
  // ****************************************************************
  pmt_pkg::pmt_ctrl_t ctrl;
  logic [7:0]         period;
  logic [7:0]         enables;
  logic [7:0]         count;
  logic               matchFlag;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl <= pmt_pkg::CTRL_RST;
    end else if (wrCtrl) begin
      ctrl <= hwdata[6:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      period <= pmt_pkg::PERIOD_RST;
    end else if (wrPer) begin
      period <= hwdata[7:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      enables <= pmt_pkg::ENAB_RST;
    end else if (wrEnab) begin
      enables <= hwdata[7:0];
    end
  end

  // ****************************************************************
  // Instruction clock enable
  // ****************************************************************
  logic [pmt_pkg::DIV_W-1:0] divCnt;
  logic                      instrTick;

  assign instrTick = (divCnt == pmt_pkg::DIV_W'(pmt_pkg::OSC_DIV - 1));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      divCnt <= '0;
    end else begin
      divCnt <= divCnt + pmt_pkg::DIV_W'(1);
    end
  end

  // ****************************************************************
  // Prescaler
  // ****************************************************************
  logic [3:0] preCnt;
  logic [3:0] preTerm;
  logic       preTick;
  logic       scalerClear;

  function automatic logic [3:0] preTermOf(input logic [1:0] sel);
    unique case (sel)
      pmt_pkg::PRE_SEL_DIV1: preTermOf = pmt_pkg::PRE_TERM_1;
      pmt_pkg::PRE_SEL_DIV4: preTermOf = pmt_pkg::PRE_TERM_4;
      default:               preTermOf = pmt_pkg::PRE_TERM_16;
    endcase
  endfunction

  assign scalerClear = wrCount | wrCtrl;
  assign preTerm     = preTermOf(ctrl.preSel);
  assign preTick     = ctrl.timerOn & instrTick & (preCnt >= preTerm);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      preCnt <= '0;
    end else if (scalerClear) begin
      preCnt <= '0;
    end else if (ctrl.timerOn && instrTick) begin
      if (preCnt >= preTerm) begin
        preCnt <= '0;
      end else begin
        preCnt <= preCnt + 4'h1;
      end
    end
  end

  // ****************************************************************
  // Counter and period match
  // ****************************************************************
  logic matchPulse;

  assign matchPulse = preTick & (count == period) & ~wrCount;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= pmt_pkg::COUNT_RST;
    end else if (wrCount) begin
      count <= hwdata[7:0];
    end else if (preTick) begin
      if (count == period) begin
        count <= pmt_pkg::COUNT_RST;
      end else begin
        count <= count + 8'h01;
      end
    end
  end

  // ****************************************************************
  // Postscaler
  // ****************************************************************
  logic [3:0] postCnt;
  logic       postEvent;

  assign postEvent = matchPulse & ~scalerClear & (postCnt >= ctrl.postSel);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      postCnt <= '0;
    end else if (scalerClear) begin
      postCnt <= '0;
    end else if (matchPulse) begin
      if (postCnt >= ctrl.postSel) begin
        postCnt <= '0;
      end else begin
        postCnt <= postCnt + 4'h1;
      end
    end
  end

  // ****************************************************************
  // Interrupt flag, request and outputs
  // ****************************************************************
  // A new event in the clearing cycle keeps the flag set.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      matchFlag <= pmt_pkg::FLAGS_RST[pmt_pkg::FLAG_MATCH_BIT];
    end else if (postEvent) begin
      matchFlag <= 1'b1;
    end else if (rdFlags) begin
      matchFlag <= 1'b0;
    end else if (wrFlags) begin
      matchFlag <= hwdata[pmt_pkg::FLAG_MATCH_BIT];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= matchFlag & enables[pmt_pkg::FLAG_MATCH_BIT];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      serialShiftMatch <= 1'b0;
      pwmTimebase      <= '0;
    end else begin
      serialShiftMatch   <= matchPulse;
      pwmTimebase.match  <= matchPulse;
      pwmTimebase.count  <= count;
      pwmTimebase.period <= period;
    end
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  logic [7:0] readByte;
  logic [7:0] flagByte;

  always_comb begin
    flagByte                          = 8'h00;
    flagByte[pmt_pkg::FLAG_MATCH_BIT] = matchFlag;
  end

  always_comb begin
    readByte = 8'h00;
    if (hitReg(dataAddr, pmt_pkg::ADDR_FLAGS)) begin
      readByte = flagByte;
    end else if (hitReg(dataAddr, pmt_pkg::ADDR_COUNT)) begin
      readByte = count;
    end else if (hitReg(dataAddr, pmt_pkg::ADDR_CTRL)) begin
      readByte = {1'b0, ctrl};
    end else if (hitReg(dataAddr, pmt_pkg::ADDR_ENAB)) begin
      readByte = enables;
    end else if (hitReg(dataAddr, pmt_pkg::ADDR_PER)) begin
      readByte = period;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hrdata <= '0;
    end else if (rdWait) begin
      hrdata <= {24'h000000, readByte};
    end
  end

endmodule

// ---- shared/pmt_pkg.sv ----
// Constants, register map and carrier types of the period match timer.
// Operation
// - Counter returns to zero after matching period.
// - Period register read/write, resets to all ones.
// - Counter read/write, cleared by every reset.
// - Quarter-rate clock, prescaled by 1, 4, 16.
// - Postscaler emits one event per N matches.
// - Event latches flag; enable gates interrupt request.
// - Timer runs only while its on bit set.
// - Counter or control write clears both scalers.
// - Control write leaves counter value untouched.
// - Unscaled match pulse goes to serial port.
// - Count and match feed PWM time-base.
// - Control bit seven reads zero; reset clears.
package pmt_pkg;

  // ****************************************************************
  // Clocking
  // ****************************************************************
  localparam int unsigned CLK_HZ  = 25_000_000;
  localparam int unsigned OSC_DIV = 4;
  localparam int unsigned DIV_W   = $clog2(OSC_DIV);

  // ****************************************************************
  // Register map: register index, byte address is four times it
  // ****************************************************************
  localparam int unsigned ADDR_W    = 12;
  localparam logic [7:0]  IDX_FLAGS = 8'h0C;
  localparam logic [7:0]  IDX_COUNT = 8'h11;
  localparam logic [7:0]  IDX_CTRL  = 8'h12;
  localparam logic [7:0]  IDX_ENAB  = 8'h8C;
  localparam logic [7:0]  IDX_PER   = 8'h92;
  localparam logic [ADDR_W-1:0] ADDR_FLAGS = {2'b00, IDX_FLAGS, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_COUNT = {2'b00, IDX_COUNT, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_CTRL  = {2'b00, IDX_CTRL, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_ENAB  = {2'b00, IDX_ENAB, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_PER   = {2'b00, IDX_PER, 2'b00};

  // ****************************************************************
  // Fields and reset values
  // ****************************************************************
  localparam int unsigned FLAG_MATCH_BIT = 1;
  localparam logic [7:0]  COUNT_RST      = 8'h00;
  localparam logic [7:0]  PERIOD_RST     = 8'hFF;
  localparam logic [7:0]  FLAGS_RST      = 8'h00;
  localparam logic [7:0]  ENAB_RST       = 8'h00;
  localparam logic [1:0]  PRE_SEL_DIV1   = 2'h0;
  localparam logic [1:0]  PRE_SEL_DIV4   = 2'h1;
  localparam logic [3:0]  PRE_TERM_1     = 4'h0;
  localparam logic [3:0]  PRE_TERM_4     = 4'h3;
  localparam logic [3:0]  PRE_TERM_16    = 4'hF;
  localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
  localparam logic [2:0]  HSIZE_WORD     = 3'h2;

  // Control register layout, bit 7 is not stored.
  typedef struct packed {
    logic [3:0] postSel;
    logic       timerOn;
    logic [1:0] preSel;
  } pmt_ctrl_t;

  localparam pmt_ctrl_t CTRL_RST = '{postSel: 4'h0, timerOn: 1'b0, preSel: 2'h0};

  // Time-base handed to the PWM units.
  typedef struct packed {
    logic [7:0] count;
    logic [7:0] period;
    logic       match;
  } pmt_pwm_t;

endpackage
